/* rtl/sram_port_map.svh */
`ifndef SRAM_PORT_MAP_SVH
`define SRAM_PORT_MAP_SVH

// Address width of the array (512K words) and number of byte lanes
`define SP_ADDR_W      19
`define SP_LANES       4
// Each lane carries eight data bits and one parity bit
`define SP_DATA_W      8
`define SP_PAR_W       1
// Width of the burst counter and low bit of its address field
`define SP_SEED_W      2
`define SP_SEED_LSB    0
// Single step of the burst counter
`define SP_STEP_ONE    2'h1
// Strap level that selects linear order
`define SP_ORDER_LIN   1'b0
// Step value the burst counter restarts from when a new address loads
`define SP_CNT_RST     2'h0
// Clock rate in MHz, kept for reference by timing users
`define SP_CLK_MHZ     250

`endif

/* rtl/sram_port_pkg.sv */
`default_nettype none
`include "sram_port_map.svh"

package sram_port_pkg;

  // Access state of the port, one-hot
  typedef enum logic [2:0] {
    ST_DESEL  = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_SLEEP  = 3'h4
  } access_state_type;

  // Burst counter state: seed from the address and steps taken
  typedef struct packed {
    logic [`SP_SEED_W-1:0] seed;
    logic [`SP_SEED_W-1:0] step;
  } burst_cnt_type;

  // Test serial path state
  typedef struct packed {
    logic tck_prev;
    logic shift;
    logic tdo;
  } test_path_type;

  // Byte write controls as sampled at one edge
  typedef struct packed {
    logic                  global_write_n;
    logic                  byte_write_enable_n;
    logic [`SP_LANES-1:0]  byte_write_select_n;
  } write_ctl_type;

endpackage

`default_nettype wire

/* rtl/burst_counter.sv */
`default_nettype none
`include "sram_port_map.svh"

// Two-bit wrapping burst counter, linear or interleaved order
module burst_counter (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  load,
  input  wire logic [`SP_SEED_W-1:0] seed_in,
  input  wire logic                  advance,
  input  wire logic                  interleaved,
  output logic      [`SP_SEED_W-1:0] cur,
  output logic      [`SP_SEED_W-1:0] inc
);

  sram_port_pkg::burst_cnt_type cnt_r;
  sram_port_pkg::burst_cnt_type cnt_nxt;
  logic [`SP_SEED_W-1:0]        step_inc;

  // Low address bits for the current and the next step; both wrap
  always_comb begin
    step_inc = cnt_r.step + `SP_STEP_ONE;
    if (interleaved) begin
      cur = cnt_r.seed ^ cnt_r.step;
      inc = cnt_r.seed ^ step_inc;
    end else begin
      cur = cnt_r.seed + cnt_r.step;
      inc = cnt_r.seed + step_inc;
    end
  end

  // Load seeds the count, advance steps it
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt.seed = seed_in;
      cnt_nxt.step = `SP_CNT_RST;
    end else if (advance) begin
      cnt_nxt.step = step_inc;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

`default_nettype wire

/* rtl/pipelined_burst_sram_port.sv */
// How it works
// - Address captured at clock rise when a strobe is low and chip selected.
// - Low two address bits seed the internal two-bit burst counter.
// - Each low byte select writes its lane only with byte write enable low.
// - Global write low writes every lane, ignoring byte enable and selects.
// - Burst counter steps at each rising edge with burst advance low and no strobe, while a burst is active.
// - Selected only when first select low, second high, third low.
// - Processor strobe ignored whenever first chip select is high.
// - With both strobes low, only the processor strobe is honoured.
// - A strobe loads full address and burst counter seed together.
// - Data and parity driven while output enable low, inputs when high.
// - First clock of a read after deselect stays tri-stated.
// - Strap low gives linear order, high interleaved; held static.
// - Sleep input, active high, idles the device but keeps contents.
// - Write data registered at clock rise; read data one clock later.
// - Each lane is eight data bits plus parity, with its own select.
// - Test serial output changes on the falling test clock edge.
// - Data outputs tri-state whenever a write cycle is detected.
// - Processor strobe writes take two clocks; controls used on second.
// - Deselect by chip selects with a strobe tri-states outputs at once.
`default_nettype none
`include "sram_port_map.svh"

module pipelined_burst_sram_port #(
  parameter int ADDR_W = `SP_ADDR_W,
  parameter int LANES  = `SP_LANES
) (
  input  wire logic                          REF_CLK,
  input  wire logic                          ARST_N,
  input  wire logic [ADDR_W-1:0]             ADDR,
  input  wire logic                          PROCESSOR_ADDR_STROBE_N,
  input  wire logic                          CONTROLLER_ADDR_STROBE_N,
  input  wire logic                          BURST_ADVANCE_N,
  input  wire logic                          GLOBAL_WRITE_N,
  input  wire logic                          BYTE_WRITE_ENABLE_N,
  input  wire logic [LANES-1:0]              BYTE_WRITE_SELECT_N,
  input  wire logic                          CHIP_SELECT_LOW_FIRST,
  input  wire logic                          CHIP_SELECT_HIGH_SECOND,
  input  wire logic                          CHIP_SELECT_LOW_THIRD,
  input  wire logic                          OUTPUT_ENABLE_N,
  input  wire logic                          BURST_ORDER_SELECT,
  input  wire logic                          SLEEP_REQUEST,
  input  wire logic [LANES*`SP_DATA_W-1:0]   DATA_LANE_IN,
  output logic      [LANES*`SP_DATA_W-1:0]   DATA_LANE_OUT,
  output logic      [LANES-1:0]              DATA_LANE_OE,
  input  wire logic [LANES*`SP_PAR_W-1:0]    PARITY_LANE_IN,
  output logic      [LANES*`SP_PAR_W-1:0]    PARITY_LANE_OUT,
  output logic      [LANES-1:0]              PARITY_LANE_OE,
  input  wire logic                          TEST_CLOCK,
  input  wire logic                          TEST_DATA_IN,
  output logic                               TEST_DATA_OUT
);

  localparam int LANE_W = `SP_DATA_W + `SP_PAR_W;
  localparam int WORD_W = LANES * LANE_W;
  localparam int DEPTH  = 1 << ADDR_W;

  // Refuse shapes the burst counter or lane split cannot serve
  if (ADDR_W <= `SP_SEED_W || ADDR_W > 24) begin : g_bad_addr
    $error("ADDR_W must be above the counter width and at most 24");
  end
  if (LANES < 1 || LANES > `SP_LANES) begin : g_bad_lanes
    $error("LANES must be between 1 and 4");
  end
  // Counter field must sit inside the captured address
  if (`SP_SEED_LSB + `SP_SEED_W > ADDR_W) begin : g_bad_seed
    $error("Burst counter field lies outside the address");
  end

  // State of the port, apart from the array and the burst counter
  typedef struct packed {
    sram_port_pkg::access_state_type state;
    logic [ADDR_W-1:0]               addr;       // Captured full address
    logic                            rd_valid;   // Read captured this edge
    logic [ADDR_W-1:0]               rd_addr;
    logic                            rd_mask;    // First read after deselect
    logic                            out_valid;  // Output register holds data
    logic                            out_mask;
    logic [WORD_W-1:0]               out_word;
    logic                            order_taken;
    logic                            interleaved;
    sram_port_pkg::test_path_type    test;
  } port_state_type;

  port_state_type st_r;
  port_state_type st_nxt;

  // Storage array, lanes packed as data then parity
  logic [WORD_W-1:0] mem [DEPTH];

  sram_port_pkg::write_ctl_type wctl;
  logic                  selected;
  logic                  proc_strobe;
  logic                  any_strobe;
  logic                  awake;
  logic [LANES-1:0]      lane_we;
  logic                  wr_ctl;
  logic                  wr_en;
  logic [ADDR_W-1:0]     wr_addr;
  logic [WORD_W-1:0]     wr_word;
  logic                  cnt_load;
  logic                  cnt_adv;
  logic [`SP_SEED_W-1:0] cnt_cur;
  logic [`SP_SEED_W-1:0] cnt_inc;
  logic [ADDR_W-1:0]     burst_addr;
  logic                  drive;
  logic                  take_access;
  logic                  take_write;
  logic                  desel_hit;
  logic                  burst_cycle;
  logic                  out_shown;
  logic                  oe_asked;
  logic                  write_seen;
  sram_port_pkg::test_path_type test_nxt;

  // Sampled write controls, padded to the full lane count
  always_comb begin
    wctl = '1;
    wctl.global_write_n      = GLOBAL_WRITE_N;
    wctl.byte_write_enable_n = BYTE_WRITE_ENABLE_N;
    wctl.byte_write_select_n[LANES-1:0] = BYTE_WRITE_SELECT_N;
  end

  // Selection, strobe priority and sleep
  always_comb begin
    selected = !CHIP_SELECT_LOW_FIRST && CHIP_SELECT_HIGH_SECOND
               && !CHIP_SELECT_LOW_THIRD;
    proc_strobe = !PROCESSOR_ADDR_STROBE_N
                  && !CHIP_SELECT_LOW_FIRST;
    any_strobe = proc_strobe || !CONTROLLER_ADDR_STROBE_N;
    awake = !SLEEP_REQUEST;
  end

  // Lane write enables from the sampled write controls
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      lane_we[i] = !wctl.global_write_n
                   || (!wctl.byte_write_enable_n
                       && !wctl.byte_write_select_n[i]);
    end
    wr_ctl = |lane_we;
  end

  // Edge kind: new access, deselect, or burst continuation
  always_comb begin
    take_access = awake && any_strobe && selected;
    take_write  = take_access && !proc_strobe && wr_ctl;
    desel_hit   = awake && any_strobe && !selected;
    burst_cycle = awake && !any_strobe
                  && st_r.state == sram_port_pkg::ST_ACTIVE;
  end

  // Write data word: each lane carries its bits plus its parity bit
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      wr_word[i*LANE_W +: LANE_W] =
        {PARITY_LANE_IN[i*`SP_PAR_W +: `SP_PAR_W],
         DATA_LANE_IN[i*`SP_DATA_W +: `SP_DATA_W]};
    end
  end

  // Burst address for this edge: upper bits held, low bits from the counter
  always_comb begin
    burst_addr = st_r.addr;
    burst_addr[`SP_SEED_LSB +: `SP_SEED_W] = cnt_adv ? cnt_inc : cnt_cur;
  end

  burst_counter u_burst (
    .clk         (REF_CLK),
    .arst_n      (ARST_N),
    .load        (cnt_load),
    .seed_in     (ADDR[`SP_SEED_LSB +: `SP_SEED_W]),
    .advance     (cnt_adv),
    .interleaved (st_r.interleaved),
    .cur         (cnt_cur),
    .inc         (cnt_inc)
  );

  // Next state: access decode, burst stepping, output pipeline, strap, test
  always_comb begin
    // Defaults: hold state, no load, no step, no write
    st_nxt   = st_r;
    cnt_load = 1'b0;
    cnt_adv  = 1'b0;
    wr_en    = 1'b0;
    wr_addr  = st_r.addr;
    st_nxt.rd_valid = 1'b0;
    st_nxt.rd_mask  = 1'b0;
    if (!awake) begin
      // Sleep: no access taken, contents kept, outputs off
      st_nxt.state     = sram_port_pkg::ST_SLEEP;
      st_nxt.out_valid = 1'b0;
    end else if (take_access) begin
      // New access: address and counter seed load together
      cnt_load     = 1'b1;
      st_nxt.addr  = ADDR;
      st_nxt.state = sram_port_pkg::ST_ACTIVE;
      if (take_write) begin
        wr_en   = 1'b1;
        wr_addr = ADDR;
      end else begin
        // Processor strobe ignores write controls on this first edge
        st_nxt.rd_valid = 1'b1;
        st_nxt.rd_addr  = ADDR;
        st_nxt.rd_mask  = st_r.state != sram_port_pkg::ST_ACTIVE;
      end
    end else if (desel_hit) begin
      // Strobe with chip deselected: drop out and float at once
      st_nxt.state     = sram_port_pkg::ST_DESEL;
      st_nxt.out_valid = 1'b0;
    end else if (burst_cycle) begin
      // Burst continuation or second clock of a processor write
      cnt_adv = !BURST_ADVANCE_N;
      if (wr_ctl) begin
        wr_en   = 1'b1;
        wr_addr = burst_addr;
      end else begin
        st_nxt.rd_valid = 1'b1;
        st_nxt.rd_addr  = burst_addr;
      end
    end else if (st_r.state == sram_port_pkg::ST_SLEEP) begin
      // Sleep left: deselected, so the next read is masked
      st_nxt.state = sram_port_pkg::ST_DESEL;
    end
    // Output register takes the word one clock after address capture
    if (awake && !desel_hit) begin
      st_nxt.out_valid = st_r.rd_valid;
      st_nxt.out_mask  = st_r.rd_mask;
      if (st_r.rd_valid) begin
        st_nxt.out_word = mem[st_r.rd_addr];
      end
    end
    // Burst order strap caught once after reset release
    if (!st_r.order_taken) begin
      st_nxt.order_taken = 1'b1;
      st_nxt.interleaved =
        BURST_ORDER_SELECT != `SP_ORDER_LIN;
    end
    // Test path takes its own next value
    st_nxt.test = test_nxt;
  end

  // Test path: input on rising, output on falling test clock
  always_comb begin
    test_nxt          = st_r.test;
    test_nxt.tck_prev = TEST_CLOCK;
    if (TEST_CLOCK && !st_r.test.tck_prev) begin
      test_nxt.shift = TEST_DATA_IN;
    end
    if (!TEST_CLOCK && st_r.test.tck_prev) begin
      test_nxt.tdo = st_r.test.shift;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r       <= '0;
      st_r.state <= sram_port_pkg::ST_DESEL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Array write, lane by lane
  always_ff @(posedge REF_CLK) begin
    if (wr_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_we[i]) begin
          mem[wr_addr][i*LANE_W +: LANE_W] <= wr_word[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Drive terms, one rule each
  always_comb begin
    out_shown  = st_r.out_valid && !st_r.out_mask;
    oe_asked   = !OUTPUT_ENABLE_N;
    write_seen = wr_ctl;
  end

  // Pin drive: any write, even on a strobe edge, floats the pins
  always_comb begin
    drive = out_shown && oe_asked && awake
            && !write_seen;
    DATA_LANE_OE   = {LANES{drive}};
    PARITY_LANE_OE = {LANES{drive}};
  end

  // Data and parity pins from the output register
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      DATA_LANE_OUT[i*`SP_DATA_W +: `SP_DATA_W] =
        st_r.out_word[i*LANE_W +: `SP_DATA_W];
      PARITY_LANE_OUT[i*`SP_PAR_W +: `SP_PAR_W] =
        st_r.out_word[i*LANE_W+`SP_DATA_W +: `SP_PAR_W];
    end
    TEST_DATA_OUT = st_r.test.tdo;
  end

endmodule

`default_nettype wire

/* verification/pipelined_burst_sram_port_assertions.sv */
`default_nettype none
// Port-level checks of the burst SRAM front end
module sram_port_checker #(
  parameter int LANES = 4
) (
  input wire logic             REF_CLK,
  input wire logic             ARST_N,
  input wire logic             PROCESSOR_ADDR_STROBE_N,
  input wire logic             CONTROLLER_ADDR_STROBE_N,
  input wire logic             GLOBAL_WRITE_N,
  input wire logic             BYTE_WRITE_ENABLE_N,
  input wire logic             CHIP_SELECT_LOW_FIRST,
  input wire logic             CHIP_SELECT_HIGH_SECOND,
  input wire logic             CHIP_SELECT_LOW_THIRD,
  input wire logic             OUTPUT_ENABLE_N,
  input wire logic             SLEEP_REQUEST,
  input wire logic [LANES-1:0] DATA_LANE_OE,
  input wire logic [LANES-1:0] PARITY_LANE_OE,
  input wire logic             TEST_CLOCK,
  input wire logic             TEST_DATA_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       stb;
  logic       sel;
  logic       rd;
  logic       ds;
  logic       tck_q;
  logic [2:0] fall_sh;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  // Access kind decoded at each edge
  assign stb = !CONTROLLER_ADDR_STROBE_N
             || (!PROCESSOR_ADDR_STROBE_N && !CHIP_SELECT_LOW_FIRST);
  assign sel = !CHIP_SELECT_LOW_FIRST && CHIP_SELECT_HIGH_SECOND
             && !CHIP_SELECT_LOW_THIRD;
  assign rd  = stb && sel && GLOBAL_WRITE_N && BYTE_WRITE_ENABLE_N
             && !SLEEP_REQUEST;
  assign ds  = stb && !sel && !SLEEP_REQUEST;

  // Recent falls of the test clock
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tck_q   <= 1'h0;
      fall_sh <= 3'h0;
    end else begin
      tck_q   <= TEST_CLOCK;
      fall_sh <= {fall_sh[1:0], tck_q && !TEST_CLOCK};
    end
  end

  AST_OE_OFF_FLOATS: assert property (
    OUTPUT_ENABLE_N |-> DATA_LANE_OE == '0) else $error("oe off driven");
  AST_SLEEP_FLOATS: assert property (
    SLEEP_REQUEST |-> DATA_LANE_OE == '0) else $error("sleep driven");
  AST_WRITE_FLOATS: assert property (
    !GLOBAL_WRITE_N |-> DATA_LANE_OE == '0) else $error("write driven");
  AST_PARITY_LANES: assert property (
    PARITY_LANE_OE == DATA_LANE_OE) else $error("parity oe differs");
  AST_DESEL_FLOATS: assert property (
    ds |=> DATA_LANE_OE == '0) else $error("deselect driven");
  AST_FIRST_READ_MASK: assert property (
    ds ##1 rd |-> ##2 DATA_LANE_OE == '0) else $error("first read driven");
  AST_READ_DRIVEN: assert property (
    (stb && sel && !SLEEP_REQUEST) ##1 rd ##1 (!SLEEP_REQUEST && !ds)
    ##1 (!OUTPUT_ENABLE_N && GLOBAL_WRITE_N && BYTE_WRITE_ENABLE_N
    && !SLEEP_REQUEST) |-> DATA_LANE_OE == '1)
    else $error("read not driven");
  AST_SERIAL_ON_FALL: assert property (
    $changed(TEST_DATA_OUT) |-> fall_sh != 3'h0) else $error("tdo edge");

  COV_DESEL_READ: cover property (ds ##1 rd);
  COV_DRIVEN: cover property (rd ##2 DATA_LANE_OE == '1);
  COV_SERIAL: cover property ($changed(TEST_DATA_OUT));
endmodule

bind pipelined_burst_sram_port sram_port_checker #(.LANES(LANES)) i_chk (
  .REF_CLK, .ARST_N, .PROCESSOR_ADDR_STROBE_N, .CONTROLLER_ADDR_STROBE_N,
  .GLOBAL_WRITE_N, .BYTE_WRITE_ENABLE_N, .CHIP_SELECT_LOW_FIRST,
  .CHIP_SELECT_HIGH_SECOND, .CHIP_SELECT_LOW_THIRD, .OUTPUT_ENABLE_N,
  .SLEEP_REQUEST, .DATA_LANE_OE, .PARITY_LANE_OE, .TEST_CLOCK,
  .TEST_DATA_OUT
);
`default_nettype wire

/* verification/sram_bus_host.sv */
`default_nettype none
// Host side of the shared data and parity bus
module sram_bus_host (
  input  wire logic        clk,
  input  wire logic        drive,
  input  wire logic [35:0] host_word,
  input  wire logic [3:0]  dev_oe,
  input  wire logic [35:0] dev_word,
  output logic      [35:0] bus_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] last_r;

  // Host drives only while the device floats; a free bus never holds data
  always_comb begin
    if (dev_oe[0]) begin
      bus_word = dev_word;
    end else if (drive) begin
      bus_word = host_word;
    end else begin
      bus_word = ~last_r;
    end
  end

  // Last bus level
  always_ff @(posedge clk) begin
    last_r <= bus_word;
  end
endmodule
`default_nettype wire

/* verification/pipelined_burst_sram_port_tb.sv */
`default_nettype none
module pipelined_burst_sram_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'h0, arst_n = 1'h0, order = 1'h0, sleep = 1'h0;
  logic          pstb_n = 1'h1, cstb_n = 1'h1, step_n = 1'h1;
  logic          wall_n = 1'h1, ben_n = 1'h1, cs1_n = 1'h0, oe_n = 1'h1;
  logic          tclk = 1'h0, tsin = 1'h0, drive = 1'h0, tsout;
  logic          cs2 = 1'h1, cs3_n = 1'h0;
  logic [3:0]    bsel_n = 4'hf, pout, doe, poe;
  logic [5:0]    addr = 6'h0;
  logic [31:0]   dout;
  logic [35:0]   hword = 36'h0, bus, mem [64];
  int            mismatches = 0;
  int            n_checks = 0;

  always #2 clk = ~clk;

  pipelined_burst_sram_port #(.ADDR_W(6), .LANES(4)) i_dut (
    .REF_CLK(clk), .ARST_N(arst_n), .ADDR(addr),
    .PROCESSOR_ADDR_STROBE_N(pstb_n), .CONTROLLER_ADDR_STROBE_N(cstb_n),
    .BURST_ADVANCE_N(step_n), .GLOBAL_WRITE_N(wall_n),
    .BYTE_WRITE_ENABLE_N(ben_n), .BYTE_WRITE_SELECT_N(bsel_n),
    .CHIP_SELECT_LOW_FIRST(cs1_n), .CHIP_SELECT_HIGH_SECOND(cs2),
    .CHIP_SELECT_LOW_THIRD(cs3_n), .OUTPUT_ENABLE_N(oe_n),
    .BURST_ORDER_SELECT(order), .SLEEP_REQUEST(sleep),
    .DATA_LANE_IN(bus[31:0]), .DATA_LANE_OUT(dout), .DATA_LANE_OE(doe),
    .PARITY_LANE_IN(bus[35:32]), .PARITY_LANE_OUT(pout),
    .PARITY_LANE_OE(poe), .TEST_CLOCK(tclk), .TEST_DATA_IN(tsin),
    .TEST_DATA_OUT(tsout));
  sram_bus_host i_host (.clk(clk), .drive(drive), .host_word(hword),
    .dev_oe(doe), .dev_word({pout, dout}), .bus_word(bus));

  task automatic tick;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic idle;
    {pstb_n, cstb_n, step_n, wall_n, ben_n, drive} = 6'h3e;
    bsel_n = 4'hf;
    tick;
  endtask

  task automatic do_reset(input logic ord);
    arst_n = 1'h0;
    order = ord;
    repeat (2) tick;
    arst_n = 1'h1;
    tick;
  endtask

  // Lanes written by a write with the given controls
  function automatic logic [35:0] merge(input logic [35:0] o, w,
                                        input logic g, be, input logic [3:0] bs);
    for (int i = 0; i < 4; i++) begin
      if (!g || (!be && !bs[i])) begin
        o[8*i +: 8] = w[8*i +: 8];
        o[32+i] = w[32+i];
      end
    end
    return o;
  endfunction

  task automatic wr(input logic [5:0] a, input logic [35:0] w,
                    input logic g, be, input logic [3:0] bs);
    {cstb_n, oe_n, drive, addr, hword} = {3'h3, a, w};
    {wall_n, ben_n, bsel_n} = {g, be, bs};
    tick;
    if (!sleep) mem[a] = merge(mem[a], w, g, be, bs);
    idle;
  endtask

  task automatic rd(input logic [5:0] a);
    {cstb_n, oe_n, addr} = {2'h0, a};
    tick;
    idle;
    chk({pout, dout}, mem[a]);
  endtask

  task automatic t_proc(input logic [5:0] a);
    {pstb_n, cstb_n, step_n, wall_n, oe_n, drive} = 6'h03;
    {addr, hword} = {a, 36'h0};
    tick;
    {pstb_n, cstb_n, step_n, wall_n, ben_n, bsel_n} = 9'h1ee;
    hword = 36'h1_aabb_ccdd;
    tick;
    mem[a] = merge(mem[a], hword, 1'h1, 1'h0, 4'he);
    idle;
    rd(a);
    $display("processor write test done");
  endtask

  task automatic t_burst(input logic ord, input logic [5:0] a);
    do_reset(ord);
    {cstb_n, oe_n, addr} = {2'h0, a};
    tick;
    cstb_n = 1'h1;
    for (int k = 0; k < 4; k++) begin
      step_n = (k == 3);
      tick;
      chk({pout, dout}, mem[{a[5:2], ord ? a[1:0] ^ 2'(k)
                                         : a[1:0] + 2'(k)}]);
    end
    idle;
    $display("burst test done");
  endtask

  task automatic t_desel(input logic [5:0] a, b);
    {pstb_n, cs1_n, oe_n} = 3'h2;
    tick;
    chk(36'(doe), 36'hf);
    {pstb_n, cstb_n, cs1_n, cs3_n} = 4'h9;
    tick;
    chk(36'(doe), 36'h0);
    {cs3_n, addr} = {1'h0, a};
    tick;
    addr = b;
    tick;
    chk({pout, dout}, mem[a]);
    chk(36'(doe), 36'h0);
    idle;
    chk({pout, dout}, mem[b]);
    chk(36'(doe), 36'hf);
    chk(36'(poe), 36'hf);
    {cstb_n, cs2} = 2'h0;
    tick;
    chk(36'(doe), 36'h0);
    cs2 = 1'h1;
    idle;
    $display("deselect test done");
  endtask

  task automatic t_sleep_serial;
    sleep = 1'h1;
    tick;
    wr(6'h11, 36'h0, 1'h0, 1'h1, 4'hf);
    sleep = 1'h0;
    tick;
    rd(6'h11);
    for (int k = 0; k < 2; k++) begin
      {tsin, tclk} = {k == 0, 1'h1};
      repeat (3) tick;
      chk(36'(tsout), 36'(k));
      tclk = 1'h0;
      repeat (3) tick;
      chk(36'(tsout), 36'(k == 0));
    end
    $display("sleep and serial test done");
  endtask

  initial begin
    do_reset(1'h0);
    for (int i = 0; i < 64; i++) begin
      wr(6'(i), {4'(i), 26'h155_5555, 6'(i)}, 1'h0, 1'h1, 4'hf);
    end
    wr(6'h0a, 36'hf_1122_3344, 1'h1, 1'h0, 4'ha);
    rd(6'h0a);
    wr(6'h0a, 36'h0_5566_7788, 1'h1, 1'h1, 4'h0);
    wr(6'h0b, 36'h6_9988_7766, 1'h0, 1'h0, 4'h5);
    rd(6'h0a);
    rd(6'h0b);
    $display("write and read test done");
    t_proc(6'h14);
    t_burst(1'h0, 6'h25);
    t_burst(1'h1, 6'h25);
    t_burst(1'h1, 6'h1b);
    t_desel(6'h0a, 6'h3c);
    t_sleep_serial;
    end_of_test;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire
